// ---- core/mic_pkg.sv ----
package mic_pkg;
    // ------------------------------------------------------------
    // frame and slot geometry
    // ------------------------------------------------------------
    localparam int SLOT_BITS = 32;
    localparam int SAMPLE_BITS = 24;
    localparam logic [4:0] SLOT_LAST = 5'h1f;
    localparam logic [4:0] SAMPLE_LAST = 5'h17;
    localparam logic [4:0] SLOT_FIRST = 5'h00;

    // ------------------------------------------------------------
    // startup timing in serial clock cycles, standby timing in system clock cycles
    // ------------------------------------------------------------
    localparam logic [18:0] NONZERO_CYCLES = 19'h0116e;
    localparam logic [18:0] VALID_CYCLES = 19'h40000;
    localparam int CLOCK_HZ = 20000000;
    localparam int STANDBY_HZ = 1000;
    // longest serial clock period still counted as running
    localparam int STANDBY_CYCLES = CLOCK_HZ / STANDBY_HZ;
    localparam logic [14:0] STANDBY_LIMIT = 15'(STANDBY_CYCLES);

    // ------------------------------------------------------------
    // unmute ramp and filters
    // ------------------------------------------------------------
    localparam logic [8:0] RAMP_FULL = 9'h100;
    localparam int RAMP_SHIFT = 8;
    // high-pass pole: corner 3.7 Hz at 48 kHz, about 2^-11 of fs divided by 2 pi
    localparam int HPF_SHIFT = 11;
    // low-pass: pair average, zero at fs/2 puts -3 dB at fs/4
    localparam int LPF_SHIFT = 1;

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_START = 2'b01,
        ST_RUN = 2'b11
    } power_t;
endpackage

// ---- core/mic_tdm_port.sv ----
`timescale 1ns/1ns
module mic_tdm_port
    import mic_pkg::*;
(
    // clock, reset, enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clock_enable,
    // link pins from the master or previous device
    input wire logic serial_clock_in,
    input wire logic frame_sync_in,
    input wire logic config_in,
    // modulator sample, one per frame
    input wire logic signed [23:0] raw_sample,
    // link pins toward the bus and next device
    output logic frame_sync_chain_out,
    output logic serial_sample_out,
    output logic serial_sample_oe,
    // status
    output logic sample_valid,
    output logic standby
);
    import mic_pkg::*;

    // overall shape of the block:
    // - every link pin crosses into the system clock through three flops
    // - a pin change counts once the second and third flops agree
    // - serial clock rises are found as edges of the agreed level
    // - frame sync is read only at those rises, like a real slave
    // - all timing counts but the watchdog are in serial clock rises, not system clocks
    // - the only system clock count is the clock-loss watchdog
    // - outputs are retimed, so they trail the pin edge by a few clocks
    // - the serial clock must stay slow against the system clock
    // - at least about five system clocks per serial clock half period
    // - a faster serial clock would let edges slip past the synchroniser
    // - the data line enable is high only while this block drives it
    // - nothing here ever drives the serial clock or the frame sync
    // - the chained frame sync is this block's only link timing output
    // - the strap is captured once, right after reset release, from cfg_level while it still holds its reset zero
    // - a clock stop resets the startup count, as a fresh power-up would

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // field notes:
    // - rst_sync: two-flop release of the asynchronous reset
    // - *_sync: three-flop pin synchronisers, newest bit at index 0
    // - *_level: agreed pin levels, only move when two stages agree
    // - cfg_taken/cfg_reg: one-shot capture of the strap
    // - power: standby, startup or run
    // - idle_cnt: system clocks since the last serial clock rise
    // - start_cnt: serial clock rises since leaving standby
    // - in_frame: frame sync seen high, waiting for it to fall
    // - bit_cnt/shift: position and contents of the outgoing word
    // - chain_*: delay line for the chained frame sync pulse
    // - ramp: unmute gain, 0 is muted and full scale is 256
    // - hp_*/lp_prev: filter memories, one update per frame
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [2:0] sck_sync;
        logic [2:0] fs_sync;
        logic [2:0] cfg_sync;
        logic sck_level;
        logic fs_level;
        logic cfg_level;
        logic cfg_taken;
        logic cfg_reg;
        power_t power;
        logic [14:0] idle_cnt;
        logic [18:0] start_cnt;
        logic in_frame;
        logic [4:0] bit_cnt;
        logic slot_active;
        logic [31:0] shift;
        logic chain_pend;
        logic [4:0] chain_cnt;
        logic chain_out;
        logic sd_out;
        logic sd_oe;
        logic [8:0] ramp;
        logic signed [23:0] hp_prev_in;
        logic signed [35:0] hp_acc;
        logic signed [23:0] lp_prev;
        logic valid;
        logic stby;
    } state_t;

    state_t cur_reg;
    state_t cur_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // saturate a wide value to 24 bits
    function automatic logic signed [23:0] sat24(
        input logic signed [37:0] v
    );
        logic signed [37:0] hi;
        logic signed [37:0] lo;
        hi = 38'sh000007fffff;
        lo = -38'sh000800000;
        if (v > hi) begin
            sat24 = 24'sh7fffff;
        end else if (v < lo) begin
            sat24 = 24'sh800000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    // agreement of second and third synchroniser stages
    function automatic logic agree(
        input logic [2:0] s,
        input logic old
    );
        if (s[1] == s[2]) begin
            agree = s[1];
        end else begin
            agree = old;
        end
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic sck_rise;
    logic fs_now;
    logic fs_start;
    logic signed [37:0] hp_out;
    logic signed [37:0] lp_sum;
    logic signed [23:0] filtered;
    logic signed [37:0] scaled;
    logic signed [23:0] word;

    // next state, one pass per system clock:
    // - synchronisers always advance while enabled
    // - the watchdog runs on system clocks and may force standby
    // - everything else but the strap capture moves only on a detected serial clock rise
    // - a frame start loads a fresh word and restarts the chain delay
    // - the msb leaves on the frame start rise itself
    // - later rises shift one bit each, the receiver takes it next rise
    // - after the lsb the line is released at once for the next device
    // hazard: the gain product must stay signed, or negative samples
    // would turn into huge positive values before saturation
    always_comb begin
        cur_next = cur_reg;
        sck_rise = 1'b0;
        fs_now = 1'b0;
        fs_start = 1'b0;
        hp_out = '0;
        lp_sum = '0;
        filtered = '0;
        scaled = '0;
        word = '0;
        cur_next.rst_sync = {cur_reg.rst_sync[0], 1'b1};
        if (clock_enable) begin
            // three-stage pin synchronisers
            cur_next.sck_sync = {cur_reg.sck_sync[1:0], serial_clock_in};
            cur_next.fs_sync = {cur_reg.fs_sync[1:0], frame_sync_in};
            cur_next.cfg_sync = {cur_reg.cfg_sync[1:0], config_in};
            cur_next.sck_level = agree(cur_reg.sck_sync, cur_reg.sck_level);
            cur_next.fs_level = agree(cur_reg.fs_sync, cur_reg.fs_level);
            cur_next.cfg_level = agree(cur_reg.cfg_sync, cur_reg.cfg_level);
            sck_rise = cur_next.sck_level && !cur_reg.sck_level;
            fs_now = cur_reg.fs_level;

            // configuration latched once after power-up
            if (!cur_reg.cfg_taken && cur_reg.rst_sync[1]) begin
                cur_next.cfg_taken = 1'b1;
                cur_next.cfg_reg = cur_reg.cfg_level;
            end

            // clock-loss watchdog drives standby
            if (sck_rise) begin
                cur_next.idle_cnt = '0;
            end else if (cur_reg.idle_cnt != STANDBY_LIMIT) begin
                cur_next.idle_cnt = cur_reg.idle_cnt + 15'h0001;
            end
            if (cur_reg.idle_cnt == STANDBY_LIMIT) begin
                cur_next.power = ST_STANDBY;
                cur_next.start_cnt = '0;
                cur_next.in_frame = 1'b0;
                cur_next.slot_active = 1'b0;
                cur_next.chain_pend = 1'b0;
                cur_next.chain_out = 1'b0;
                cur_next.sd_oe = 1'b0;
                cur_next.sd_out = 1'b0;
                cur_next.ramp = '0;
            end

            if (sck_rise) begin
                // power state and startup counter
                case (cur_reg.power)
                    ST_STANDBY: begin
                        cur_next.power = ST_START;
                        cur_next.start_cnt = '0;
                    end
                    ST_START: begin
                        cur_next.start_cnt = cur_reg.start_cnt + 19'h00001;
                        if (cur_next.start_cnt == VALID_CYCLES) begin
                            cur_next.power = ST_RUN;
                        end
                    end
                    ST_RUN: begin
                    end
                    default: begin
                        cur_next.power = ST_STANDBY;
                    end
                endcase

                // frame start on a rising frame sync sample
                fs_start = fs_now && !cur_reg.in_frame;
                if (!fs_now) begin
                    cur_next.in_frame = 1'b0;
                end else if (fs_start) begin
                    cur_next.in_frame = 1'b1;
                end

                // chained frame sync one slot later
                if (fs_start) begin
                    cur_next.chain_pend = 1'b1;
                    cur_next.chain_cnt = SLOT_FIRST;
                end else if (cur_reg.chain_pend) begin
                    cur_next.chain_cnt = cur_reg.chain_cnt + 5'h01;
                    if (cur_reg.chain_cnt == SLOT_LAST - 5'h01) begin
                        cur_next.chain_pend = 1'b0;
                        cur_next.chain_out = 1'b1;
                    end
                end else if (cur_reg.chain_out) begin
                    cur_next.chain_out = 1'b0;
                end

                // slot shifter: launch bit per rising edge
                if (fs_start) begin
                    // filter pipeline once per frame
                    hp_out = 38'(cur_reg.hp_acc) + 38'(raw_sample)
                        - 38'(cur_reg.hp_prev_in)
                        - (38'(cur_reg.hp_acc) >>> HPF_SHIFT);
                    cur_next.hp_acc = hp_out[35:0];
                    cur_next.hp_prev_in = raw_sample;
                    lp_sum = (hp_out + 38'(cur_reg.lp_prev)) >>> LPF_SHIFT;
                    cur_next.lp_prev = sat24(hp_out);
                    filtered = sat24(lp_sum);
                    scaled = (38'(filtered)
                        * 38'(signed'({1'b0, cur_reg.ramp})))
                        >>> RAMP_SHIFT;
                    word = sat24(scaled);
                    if (cur_reg.power == ST_STANDBY
                        || (cur_reg.power == ST_START
                        && cur_reg.start_cnt < NONZERO_CYCLES)) begin
                        word = '0;
                    end else if (cur_reg.ramp != RAMP_FULL) begin
                        cur_next.ramp = cur_reg.ramp + 9'h001;
                    end
                    // 24-bit msb-first word padded in 32-bit slot
                    cur_next.shift = {word, 8'h00};
                    cur_next.bit_cnt = SLOT_FIRST;
                    cur_next.slot_active = 1'b1;
                    cur_next.sd_oe = 1'b1;
                    cur_next.sd_out = word[SAMPLE_BITS-1];
                end else if (cur_reg.slot_active) begin
                    cur_next.bit_cnt = cur_reg.bit_cnt + 5'h01;
                    cur_next.shift = {cur_reg.shift[30:0], 1'b0};
                    if (cur_reg.bit_cnt == SAMPLE_LAST) begin
                        cur_next.slot_active = 1'b0;
                        cur_next.sd_oe = 1'b0;
                        cur_next.sd_out = 1'b0;
                    end else begin
                        cur_next.sd_out = cur_reg.shift[30];
                    end
                end
            end

            // normal operation needs both link clocks
            cur_next.valid = (cur_next.power == ST_RUN)
                && cur_next.in_frame | cur_reg.valid
                && (cur_next.power == ST_RUN);
            cur_next.stby = (cur_next.power == ST_STANDBY);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset notes:
    // - the asynchronous branch loads only constants
    // - while the release flops are still low the state stays zero
    // - only the release flops themselves advance then
    // - power starts in standby, so the first rise begins startup
    // - all outputs but standby read zero from reset until the first frame
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg <= '0;
        end else if (!cur_reg.rst_sync[1]) begin
            cur_reg <= '0;
            cur_reg.rst_sync <= cur_next.rst_sync;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    // no logic between the state flops and the pins, so the data line,
    // its enable and the chained frame sync change together and glitch
    // free, one system clock after the rise that was detected
    assign frame_sync_chain_out = cur_reg.chain_out;
    assign serial_sample_out = cur_reg.sd_out;
    assign serial_sample_oe = cur_reg.sd_oe;
    assign sample_valid = cur_reg.valid;
    assign standby = cur_reg.stby;
endmodule

// ---- tb/mic_tdm_checker.sv ----
`timescale 1ns/1ns
// ------------
// port checker
// ------------
module mic_tdm_checker (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // link inputs
    input wire logic serial_clock_in,
    input wire logic frame_sync_in,
    // device outputs
    input wire logic frame_sync_chain_out,
    input wire logic serial_sample_out,
    input wire logic serial_sample_oe,
    input wire logic sample_valid,
    input wire logic standby
);
    logic sck_reg;
    logic rise;
    logic [4:0] oe_rises;
    logic [4:0] since_rise;
    logic [3:0] fs_age;
    logic [12:0] run_rises;
    logic [14:0] idle_cnt;
    assign rise = serial_clock_in && !sck_reg;
    // counters of serial clock activity
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_reg <= 1'b0;
            oe_rises <= 5'h00;
            since_rise <= 5'h00;
            fs_age <= 4'h0;
            run_rises <= 13'h0000;
            idle_cnt <= 15'h0000;
        end else begin
            sck_reg <= serial_clock_in;
            oe_rises <= serial_sample_oe ? oe_rises + 5'(rise) : 5'h00;
            since_rise <= rise ? 5'h00 : since_rise + 5'h01;
            fs_age <= frame_sync_in ? 4'h0 : fs_age + 4'(fs_age != 4'hf);
            run_rises <= standby ? 13'h0000 : run_rises + 13'(rise);
            idle_cnt <= (serial_clock_in != sck_reg) ? 15'h0000
                : idle_cnt + 15'h0001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence chain_high;
        frame_sync_chain_out [*6];
    endsequence
    sequence chain_low;
        !frame_sync_chain_out;
    endsequence
    AST_CHAIN_PULSE: assert property ($rose(frame_sync_chain_out) |->
        chain_high ##[1:4] chain_low) else $error("chain pulse width wrong");
    AST_CHAIN_AFTER: assert property ($fell(serial_sample_oe) && !standby
        |-> ##[50:62] $rose(frame_sync_chain_out)) else $error("chain late");
    AST_OE_WIDTH: assert property ($fell(serial_sample_oe) && !standby
        |-> oe_rises == 5'h18) else $error("slot word not 24 bits");
    AST_BIT_STEADY: assert property (serial_sample_oe
        && $changed(serial_sample_out) |-> since_rise inside {[1:7]})
        else $error("data bit changed away from clock rise");
    AST_IDLE_ZERO: assert property (!serial_sample_oe
        |-> !serial_sample_out) else $error("data while released");
    AST_STANDBY_QUIET: assert property (standby
        |-> !serial_sample_oe && !sample_valid) else $error("busy in standby");
    AST_STANDBY_ENTRY: assert property (idle_cnt == 15'h4e84
        |-> standby) else $error("no standby after clock stop");
    AST_ZERO_EARLY: assert property (serial_sample_oe
        && run_rises < 13'h1130 |-> !serial_sample_out)
        else $error("nonzero data during startup");
    AST_OE_AFTER_FS: assert property ($rose(serial_sample_oe)
        |-> fs_age < 4'h9) else $error("slot without frame sync");
endmodule

bind mic_tdm_port mic_tdm_checker mic_tdm_checker_i (
    .clock(clock), .reset_n(reset_n), .serial_clock_in(serial_clock_in),
    .frame_sync_in(frame_sync_in), .frame_sync_chain_out(frame_sync_chain_out),
    .serial_sample_out(serial_sample_out),
    .serial_sample_oe(serial_sample_oe), .sample_valid(sample_valid),
    .standby(standby));

// ---- tb/tdm_master_model.sv ----
`timescale 1ns/1ns
// -------------------------
// clock master and receiver
// -------------------------
module tdm_master_model #(
    parameter int LEAD = 16
) (
    // control and pulled-down data line
    input wire logic run,
    input wire logic data_line,
    // link pins toward the device
    output logic serial_clock,
    output logic frame_sync,
    // last captured word
    output logic [23:0] word,
    output int words
);
    int n;
    int m;
    // 64 clocks a frame, frames always finish before the clocks stop
    // two devices at most on this bus, so 2 x 32 clocks a frame
    // clocks held low while the run input is low, once the current frame has finished
    initial begin
        serial_clock = 1'b0;
        frame_sync = 1'b0;
        word = 24'h000000;
        words = 0;
        #7;
        forever begin
            serial_clock = 1'b0;
            frame_sync = 1'b0;
            n = 0;
            m = -1;
            wait (run);
            while (run || m > 0) begin
                frame_sync = (m == 0);
                #200;
                serial_clock = 1'b1;
                if (m >= 1 && m <= 24) begin
                    word = {word[22:0], data_line};
                end
                if (m == 24) begin
                    words = words + 1;
                end
                #200;
                serial_clock = 1'b0;
                n = n + 1;
                m = (n < LEAD) ? -1 : (n - LEAD) % 64;
            end
        end
    end
endmodule

// ---- tb/test_mic_tdm_port.sv ----
`timescale 1ns/1ns
module test_mic_tdm_port;
    import mic_pkg::*;
    typedef struct {
        logic [23:0] smp;
        logic [23:0] exp;
    } row_t;
    logic clock;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic [23:0] raw_sample = 24'h000000;
    logic sck, fs, chain, sd, oe, valid, stby;
    logic [23:0] word;
    logic nz;
    int words;
    int f;
    int failures = 0;
    int checked = 0;
    wire data_line = oe ? sd : 1'b0;
    row_t rows [4] = '{'{24'h7fffff, 24'h0}, '{24'h800000, 24'h0},
        '{24'h000001, 24'h0}, '{24'hffffff, 24'h0}};
    mic_tdm_port mic_tdm_port_i (.clock(clock), .reset_n(reset_n),
        .clock_enable(1'b1), .serial_clock_in(sck), .frame_sync_in(fs),
        .config_in(1'b1), .raw_sample(raw_sample),
        .frame_sync_chain_out(chain), .serial_sample_out(sd),
        .serial_sample_oe(oe), .sample_valid(valid), .standby(stby));
    tdm_master_model #(.LEAD(16)) tdm_master_model_i (.run(run),
        .data_line(data_line), .serial_clock(sck), .frame_sync(fs),
        .word(word), .words(words));
    // system clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // compare tasks
    task automatic check_word(input string name, input logic [23:0] e,
        input logic [23:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic check_bit(input string name, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask
    // wait for the master to capture one word
    task automatic next_word();
        int w0;
        int k;
        w0 = words;
        k = 0;
        while (words == w0 && k < 4000) begin
            @(posedge clock);
            k++;
        end
        check_bit("word_arrived", 1'b1, 1'(words != w0));
    endtask
    task automatic results();
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        results();
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        #5 reset_n = 1'b1;
        run = 1'b1;
        foreach (rows[i]) begin
            @(posedge clock);
            #5 raw_sample = rows[i].smp;
            next_word();
            check_word("early_word", rows[i].exp, word);
        end
        check_bit("valid_early", 1'b0, valid);
        check_bit("standby_run", 1'b0, stby);
        // pattern that passes both filters until output appears
        nz = 1'b0;
        f = 0;
        while (f < 100 && !nz) begin
            @(posedge clock);
            #5 raw_sample = f[1] ? 24'hc00000 : 24'h400000;
            next_word();
            nz = (word !== 24'h000000);
            f++;
        end
        check_bit("output_starts", 1'b1, nz);
        check_bit("zero_until_start", 1'b1, 1'(f + 3 >= 69));
        check_bit("ramp_small", 1'b1, 1'(word[23:20] == 4'h0
            || word[23:20] == 4'hf));
        check_bit("valid_late", 1'b0, valid);
        @(posedge clock);
        #5 run = 1'b0;
        repeat (21000) @(posedge clock);
        #5;
        check_bit("standby_on", 1'b1, stby);
        check_bit("oe_released", 1'b0, oe);
        run = 1'b1;
        next_word();
        check_word("restart_word", 24'h000000, word);
        check_bit("standby_off", 1'b0, stby);
        repeat (400) @(posedge clock);
        #5 reset_n = 1'b0;
        #1;
        check_bit("oe_reset", 1'b0, oe);
        check_bit("chain_reset", 1'b0, chain);
        results();
    end
endmodule
